// ===== monitor_pkg.sv
// shared constants for the per-processor resource monitoring front end
// assumes one core clock and a register access port driven by core logic
// ============================================================
package monitor_pkg;

  // ============================================================
  // sizes
  localparam int NUM_LP = 2;                 // logical processors served
  localparam int ID_W   = 10;                // monitor ID field width
  localparam int NUM_ID = 16;                // implemented counter sets
  localparam int IDX_W  = 4;                 // index into counter sets
  localparam int EVT_W  = 8;                 // event code width
  localparam int CNT_W  = 32;                // accumulator width
  localparam int DATA_W = 64;                // model register width
  localparam int Q_W    = 32;                // query register width
  localparam int LP_W   = 1;                 // processor select width

  localparam logic [ID_W-1:0] MAX_ID = 10'h00F; // highest supported ID

  // ============================================================
  // register selectors and field layout
  typedef enum logic [1:0] {
    REG_ASSOC  = 2'h0,                       // thread_monitor_id_assoc
    REG_EVTSEL = 2'h1,                       // monitor_event_select
    REG_CTR    = 2'h2                        // monitor_result_counter
  } reg_sel_t;

  localparam int ID_LSB      = 0;            // ID in association register
  localparam int EVT_LSB     = 0;            // event code in event select
  localparam int EVT_ID_LSB  = 32;           // ID in event select
  localparam int ERR_BIT     = 63;           // counter error flag
  localparam int UNAVAIL_BIT = 62;           // counter data unavailable

  // ============================================================
  // event codes
  localparam logic [EVT_W-1:0] EV_OCC = 8'h01; // cache occupancy
  localparam logic [EVT_W-1:0] EV_TOT = 8'h02; // total external bandwidth
  localparam logic [EVT_W-1:0] EV_LOC = 8'h03; // local external bandwidth

  // ============================================================
  // capability query
  localparam logic [Q_W-1:0] LEAF_FEAT = 32'h0000_0007;
  localparam logic [Q_W-1:0] LEAF_MON  = 32'h0000_000F;
  localparam logic [Q_W-1:0] SUB_ZERO  = 32'h0000_0000;
  localparam int SUPPORT_BIT = 12;           // monitor_support_flag
  localparam int LLC_RES_BIT = 1;            // last-level cache resource

endpackage : monitor_pkg

// ===== shared_resource_monitor_ids.sv
// per-processor monitor ID tagging, per-ID cache metric counters and
// the capability query that software uses to discover them
// assumes all inputs come from core logic on clk_sys, none need syncing
`timescale 1ns/1ps
module shared_resource_monitor_ids (
  input  wire logic                                  clk_sys,     // core clock, 200 MHz
  input  wire logic                                  resetn,      // async reset, active low
  // model register write
  input  wire logic                                  wrValid,     // one-cycle write request
  input  wire logic [1:0]                            wrSel,       // register selector
  input  wire logic [monitor_pkg::LP_W-1:0]          wrLp,        // target processor
  input  wire logic [monitor_pkg::DATA_W-1:0]        wrData,      // write value
  // model register read
  input  wire logic                                  rdValid,     // one-cycle read request
  input  wire logic [1:0]                            rdSel,       // register selector
  input  wire logic [monitor_pkg::LP_W-1:0]          rdLp,        // source processor
  // capability query
  input  wire logic                                  queryValid,  // one-cycle query request
  input  wire logic [monitor_pkg::Q_W-1:0]           queryLeaf,   // leaf number
  input  wire logic [monitor_pkg::Q_W-1:0]           querySub,    // sub-leaf number
  // cache traffic, tagged with each processor's active ID; evictions carry the owner ID in evictId
  input  wire logic [monitor_pkg::NUM_LP-1:0]        fillPulse,   // line allocated
  input  wire logic [monitor_pkg::NUM_LP-1:0]        missPulse,   // external transfer
  input  wire logic [monitor_pkg::NUM_LP-1:0]        missLocal,   // transfer served locally
  input  wire logic                                  evictPulse,  // line removed
  input  wire logic [monitor_pkg::ID_W-1:0]          evictId,     // owner of removed line
  // answers
  output logic                                       wrDone,      // write finished pulse
  output logic                                       gpFault,     // write rejected pulse
  output logic                                       rdDone,      // read data valid pulse
  output logic [monitor_pkg::DATA_W-1:0]             rdData,      // read value, held
  output logic                                       queryDone,   // query answer pulse
  output logic [monitor_pkg::Q_W-1:0]                queryEbx,    // query result EBX
  output logic [monitor_pkg::Q_W-1:0]                queryEdx,    // query result EDX
  output logic [monitor_pkg::NUM_LP-1:0][monitor_pkg::ID_W-1:0] activeId // tag per processor
);

  // ============================================================
  // state
  typedef logic [monitor_pkg::NUM_ID-1:0][monitor_pkg::CNT_W-1:0] cnt_bank_t;

  typedef struct packed {
    logic [monitor_pkg::NUM_LP-1:0][monitor_pkg::ID_W-1:0]  assocId;  // active ID
    logic [monitor_pkg::NUM_LP-1:0][monitor_pkg::EVT_W-1:0] evtCode;  // selected event
    logic [monitor_pkg::NUM_LP-1:0][monitor_pkg::ID_W-1:0]  monitor_event_code;    // selected ID
    cnt_bank_t                                              occ;      // lines held
    cnt_bank_t                                              tot;      // total transfers
    cnt_bank_t                                              loc;      // local transfers
    logic                                                   wrDone;
    logic                                                   gpFault;
    logic                                                   rdDone;
    logic [monitor_pkg::DATA_W-1:0]                         rdData;
    logic                                                   queryDone;
    logic [monitor_pkg::Q_W-1:0]                            queryEbx;
    logic [monitor_pkg::Q_W-1:0]                            queryEdx;
  } state_t;

  state_t state_reg;   // registered state
  state_t state_next;  // next value

  // ============================================================
  // helpers
  // true when an event code is one of the three decoded ones
  function automatic logic code_known(input logic [monitor_pkg::EVT_W-1:0] c);
    code_known = (c == monitor_pkg::EV_OCC) || (c == monitor_pkg::EV_TOT) ||
                 (c == monitor_pkg::EV_LOC);
  endfunction : code_known

  logic [monitor_pkg::ID_W-1:0] wrAssocId;  // ID field of a write to association
  logic [monitor_pkg::ID_W-1:0] wrEvtId;    // ID field of a write to event select
  logic [monitor_pkg::EVT_W-1:0] wrEvtCode; // code field of a write to event select
  logic [monitor_pkg::EVT_W-1:0] selCode;   // event code of the reading processor
  logic [monitor_pkg::ID_W-1:0]  selId;     // selected ID of the reading processor
  logic                          selBad;    // lookup cannot be served
  logic [monitor_pkg::IDX_W-1:0] selIdx;    // counter set index

  assign wrAssocId = wrData[monitor_pkg::ID_LSB +: monitor_pkg::ID_W];
  assign wrEvtId   = wrData[monitor_pkg::EVT_ID_LSB +: monitor_pkg::ID_W];
  assign wrEvtCode = wrData[monitor_pkg::EVT_LSB +: monitor_pkg::EVT_W];
  assign selCode   = state_reg.evtCode[rdLp];
  assign selId     = state_reg.monitor_event_code[rdLp];
  assign selBad    = !code_known(selCode) || (selId > monitor_pkg::MAX_ID);
  assign selIdx    = selId[monitor_pkg::IDX_W-1:0];

  // ============================================================
  // next state
  // counters run every cycle; the read port only samples them, which keeps
  // the read free of side effects at the cost of a one-cycle old snapshot
  always_comb begin
    logic [monitor_pkg::CNT_W-1:0] addOcc;
    logic [monitor_pkg::CNT_W-1:0] addTot;
    logic [monitor_pkg::CNT_W-1:0] addLoc;
    logic [monitor_pkg::CNT_W-1:0] cval;
    addOcc = '0;
    addTot = '0;
    addLoc = '0;
    cval   = '0;
    state_next           = state_reg;
    state_next.wrDone    = 1'b0;
    state_next.gpFault   = 1'b0;
    state_next.rdDone    = 1'b0;
    state_next.queryDone = 1'b0;

    // per-ID accumulation of traffic from every processor
    for (int id = 0; id < monitor_pkg::NUM_ID; id++) begin
      addOcc = '0;
      addTot = '0;
      addLoc = '0;
      // each processor's traffic counts against its own active ID
      for (int lp = 0; lp < monitor_pkg::NUM_LP; lp++) begin
        if (state_reg.assocId[lp] == monitor_pkg::ID_W'(id)) begin
          addOcc = addOcc + monitor_pkg::CNT_W'(fillPulse[lp]);
          addTot = addTot + monitor_pkg::CNT_W'(missPulse[lp]);
          addLoc = addLoc + monitor_pkg::CNT_W'(missPulse[lp] & missLocal[lp]);
        end
      end
      // an eviction of an empty set is dropped so occupancy never wraps
      if (evictPulse && (evictId == monitor_pkg::ID_W'(id)) && (state_reg.occ[id] != '0)) begin
        state_next.occ[id] = state_reg.occ[id] + addOcc - monitor_pkg::CNT_W'(1);
      end else begin
        state_next.occ[id] = state_reg.occ[id] + addOcc;
      end
      state_next.tot[id] = state_reg.tot[id] + addTot;
      state_next.loc[id] = state_reg.loc[id] + addLoc;
    end

    // register writes
    if (wrValid) begin
      unique case (monitor_pkg::reg_sel_t'(wrSel))
        monitor_pkg::REG_ASSOC: begin
          if (wrAssocId > monitor_pkg::MAX_ID) begin
            state_next.gpFault = 1'b1;
          end else begin
            state_next.assocId[wrLp] = wrAssocId;
            state_next.wrDone        = 1'b1;
          end
        end
        monitor_pkg::REG_EVTSEL: begin
          // stored as written; a bad pair is reported at counter read time
          state_next.evtCode[wrLp] = wrEvtCode;
          state_next.monitor_event_code[wrLp]   = wrEvtId;
          state_next.wrDone        = 1'b1;
        end
        default: begin
          // the counter is read only, as is the unused selector code
          state_next.gpFault = 1'b1;
        end
      endcase
    end

    // register reads; only here is counter data sampled
    if (rdValid) begin
      state_next.rdDone = 1'b1;
      state_next.rdData = '0;
      unique case (monitor_pkg::reg_sel_t'(rdSel))
        monitor_pkg::REG_ASSOC: begin
          state_next.rdData[monitor_pkg::ID_LSB +: monitor_pkg::ID_W] = state_reg.assocId[rdLp];
        end
        monitor_pkg::REG_EVTSEL: begin
          state_next.rdData[monitor_pkg::EVT_LSB +: monitor_pkg::EVT_W]   = selCode;
          state_next.rdData[monitor_pkg::EVT_ID_LSB +: monitor_pkg::ID_W] = selId;
        end
        monitor_pkg::REG_CTR: begin
          if (selBad) begin
            // error with no data
            state_next.rdData[monitor_pkg::ERR_BIT]     = 1'b1;
            state_next.rdData[monitor_pkg::UNAVAIL_BIT] = 1'b1;
          end else begin
            // lookup by selected code and ID
            if (selCode == monitor_pkg::EV_OCC) begin
              cval = state_reg.occ[selIdx];
            end else if (selCode == monitor_pkg::EV_TOT) begin
              cval = state_reg.tot[selIdx];
            end else begin
              cval = state_reg.loc[selIdx];
            end
            state_next.rdData[monitor_pkg::CNT_W-1:0] = cval;
          end
        end
        default: begin
          // unused selector reads as zero
          state_next.rdData = '0;
        end
      endcase
    end

    // capability query
    if (queryValid) begin
      state_next.queryDone = 1'b1;
      state_next.queryEbx  = '0;
      state_next.queryEdx  = '0;
      if ((queryLeaf == monitor_pkg::LEAF_FEAT) && (querySub == monitor_pkg::SUB_ZERO)) begin
        state_next.queryEbx[monitor_pkg::SUPPORT_BIT] = 1'b1;
      end else if ((queryLeaf == monitor_pkg::LEAF_MON) && (querySub == monitor_pkg::SUB_ZERO)) begin
        // only the cache resource bit; all higher bits stay zero
        state_next.queryEdx[monitor_pkg::LLC_RES_BIT] = 1'b1;
        state_next.queryEbx = monitor_pkg::Q_W'(monitor_pkg::MAX_ID);
      end
    end
  end

  // ============================================================
  // state register
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_reg <= '0;   // IDs, selects and counters all start at zero
    end else begin
      state_reg <= state_next;
    end
  end

  // ============================================================
  // outputs, straight from the state register
  assign wrDone    = state_reg.wrDone;
  assign gpFault   = state_reg.gpFault;
  assign rdDone    = state_reg.rdDone;
  assign rdData    = state_reg.rdData;
  assign queryDone = state_reg.queryDone;
  assign queryEbx  = state_reg.queryEbx;
  assign queryEdx  = state_reg.queryEdx;
  assign activeId  = state_reg.assocId;

  // ============================================================
  // checks
  sequence s_assoc_wr_ok;
    wrValid && (wrSel == monitor_pkg::REG_ASSOC) && (wrAssocId <= monitor_pkg::MAX_ID);
  endsequence

  sequence s_ctr_rd;
    rdValid && (rdSel == monitor_pkg::REG_CTR);
  endsequence

  a_assoc_replace: assert property (@(posedge clk_sys) disable iff (!resetn)
    s_assoc_wr_ok |=> (activeId[$past(wrLp)] == $past(wrAssocId)) && wrDone && !gpFault)
    else $error("association write did not replace active ID");

  a_assoc_other_kept: assert property (@(posedge clk_sys) disable iff (!resetn)
    s_assoc_wr_ok |=> activeId[!$past(wrLp)] == $past(activeId[!wrLp]))
    else $error("association write disturbed another processor");

  a_gp_big_id: assert property (@(posedge clk_sys) disable iff (!resetn)
    (wrValid && (wrSel == monitor_pkg::REG_ASSOC) && (wrAssocId > monitor_pkg::MAX_ID))
      |=> gpFault && !wrDone && $stable(activeId))
    else $error("oversize ID not rejected");

  a_ctr_error: assert property (@(posedge clk_sys) disable iff (!resetn)
    (s_ctr_rd and selBad) |=> rdDone && rdData[monitor_pkg::ERR_BIT] && rdData[monitor_pkg::UNAVAIL_BIT])
    else $error("bad selection read without error flag");

  a_ctr_valid: assert property (@(posedge clk_sys) disable iff (!resetn)
    (s_ctr_rd and !selBad) |=> rdDone && !rdData[monitor_pkg::ERR_BIT] && !rdData[monitor_pkg::UNAVAIL_BIT])
    else $error("good selection read flagged as error");

  a_occ_lookup: assert property (@(posedge clk_sys) disable iff (!resetn)
    (s_ctr_rd and !selBad && (selCode == monitor_pkg::EV_OCC))
      |=> rdData[monitor_pkg::CNT_W-1:0] == $past(state_reg.occ[selIdx]))
    else $error("occupancy lookup returned wrong set");

  a_tot_counts: assert property (@(posedge clk_sys) disable iff (!resetn)
    (missPulse == 2'h1) && (activeId[0] < monitor_pkg::ID_W'(monitor_pkg::NUM_ID)) &&
      (activeId[1] != activeId[0])
      |=> state_reg.tot[$past(activeId[0][monitor_pkg::IDX_W-1:0])] ==
          $past(state_reg.tot[activeId[0][monitor_pkg::IDX_W-1:0]]) + monitor_pkg::CNT_W'(1))
    else $error("transfer not counted against active ID");

  a_rd_sampled: assert property (@(posedge clk_sys) disable iff (!resetn)
    !rdValid |=> !rdDone && $stable(rdData))
    else $error("read data changed without a read");

  a_support_flag: assert property (@(posedge clk_sys) disable iff (!resetn)
    (queryValid && (queryLeaf == monitor_pkg::LEAF_FEAT) && (querySub == monitor_pkg::SUB_ZERO))
      |=> queryDone && queryEbx[monitor_pkg::SUPPORT_BIT])
    else $error("support flag missing");

  a_res_vector: assert property (@(posedge clk_sys) disable iff (!resetn)
    (queryValid && (queryLeaf == monitor_pkg::LEAF_MON) && (querySub == monitor_pkg::SUB_ZERO))
      |=> (queryEdx == 32'h0000_0002) && (queryEbx == 32'h0000_000F))
    else $error("resource enumeration wrong");

  // the two bandwidth lookups follow the same pre-update snapshot rule
  a_tot_lookup: assert property (@(posedge clk_sys) disable iff (!resetn)
    (s_ctr_rd and !selBad && (selCode == monitor_pkg::EV_TOT))
      |=> rdData[monitor_pkg::CNT_W-1:0] == $past(state_reg.tot[selIdx]))
    else $error("total bandwidth lookup returned wrong set");

  a_loc_lookup: assert property (@(posedge clk_sys) disable iff (!resetn)
    (s_ctr_rd and !selBad && (selCode == monitor_pkg::EV_LOC))
      |=> rdData[monitor_pkg::CNT_W-1:0] == $past(state_reg.loc[selIdx]))
    else $error("local bandwidth lookup returned wrong set");

  // an event select write is always taken; a bad pair only shows at counter read
  a_evtsel_taken: assert property (@(posedge clk_sys) disable iff (!resetn)
    (wrValid && (wrSel == monitor_pkg::REG_EVTSEL))
      |=> wrDone && !gpFault)
    else $error("event select write not accepted");

  // resource bits above the cache resource bit never show in any query answer
  a_res_reserved: assert property (@(posedge clk_sys) disable iff (!resetn)
    queryDone |-> (queryEdx[monitor_pkg::Q_W-1:monitor_pkg::LLC_RES_BIT+1] == '0))
    else $error("reserved resource bit set");

  // a write gets exactly one of the two answers, never both
  a_wr_one_answer: assert property (@(posedge clk_sys) disable iff (!resetn)
    !(wrDone && gpFault))
    else $error("write both accepted and rejected");

endmodule : shared_resource_monitor_ids

// ===== test_shared_resource_monitor_ids.sv
// self-checking bench for the monitor ID front end: tagging, counters, query
// assumes the design answers one cycle after each request, as handed over
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value %s expected %0h seen %0h", n, e, g); end end
module test_shared_resource_monitor_ids;
  // ============================================================
  // design connections
  logic                                                 clk_sys;
  logic                                                 resetn;
  logic                                                 wrValid;
  logic [1:0]                                           wrSel;
  logic [monitor_pkg::LP_W-1:0]                         wrLp;
  logic [monitor_pkg::DATA_W-1:0]                       wrData;
  logic                                                 rdValid;
  logic [1:0]                                           rdSel;
  logic [monitor_pkg::LP_W-1:0]                         rdLp;
  logic                                                 queryValid;
  logic [monitor_pkg::Q_W-1:0]                          queryLeaf;
  logic [monitor_pkg::Q_W-1:0]                          querySub;
  logic [monitor_pkg::NUM_LP-1:0]                       fillPulse;
  logic [monitor_pkg::NUM_LP-1:0]                       missPulse;
  logic [monitor_pkg::NUM_LP-1:0]                       missLocal;
  logic                                                 evictPulse;
  logic [monitor_pkg::ID_W-1:0]                         evictId;
  logic                                                 wrDone;
  logic                                                 gpFault;
  logic                                                 rdDone;
  logic [monitor_pkg::DATA_W-1:0]                       rdData;
  logic                                                 queryDone;
  logic [monitor_pkg::Q_W-1:0]                          queryEbx;
  logic [monitor_pkg::Q_W-1:0]                          queryEdx;
  logic [monitor_pkg::NUM_LP-1:0][monitor_pkg::ID_W-1:0] activeId;
  // ============================================================
  // reference model and expectation queues
  int unsigned       occ [16];  // occupancy per ID
  int unsigned       tot [16];  // total transfers per ID
  int unsigned       loc [16];  // local transfers per ID
  logic [9:0]        aid [2];   // active ID per processor
  logic [1:0]        wrQ [$];   // expected {done, fault}
  logic [63:0]       rdQ [$];   // expected read data
  logic [63:0]       qQ  [$];   // expected {ebx, edx}
  int                fail_count = 0;
  int                checks = 0;
  localparam logic [63:0] ERRV = 64'hC000_0000_0000_0000; // error and unavailable together
  shared_resource_monitor_ids dut_u (.clk_sys(clk_sys), .resetn(resetn), .wrValid(wrValid), .wrSel(wrSel),
    .wrLp(wrLp), .wrData(wrData), .rdValid(rdValid), .rdSel(rdSel), .rdLp(rdLp), .queryValid(queryValid),
    .queryLeaf(queryLeaf), .querySub(querySub), .fillPulse(fillPulse), .missPulse(missPulse),
    .missLocal(missLocal), .evictPulse(evictPulse), .evictId(evictId), .wrDone(wrDone), .gpFault(gpFault),
    .rdDone(rdDone), .rdData(rdData), .queryDone(queryDone), .queryEbx(queryEbx), .queryEdx(queryEdx),
    .activeId(activeId));
  // ============================================================
  // clock, 5 ns period
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // ============================================================
  // request tasks: each starts and ends 1 ns after a rising edge
  task automatic wr(input logic [1:0] sel, input int lp, input logic [63:0] d, input logic flt);
    wrSel = sel; wrLp = lp[0:0]; wrData = d; wrValid = 1'b1;
    wrQ.push_back({~flt, flt});
    @(posedge clk_sys); #1 wrValid = 1'b0;
    @(posedge clk_sys); #1; // idle edge so the next call never re-raises in this step
    if (!flt && sel == 2'h0) aid[lp] = d[9:0];
    // both processors compared so a write cannot leak to the other one
    `CHK("activeId0", aid[0], activeId[0])
    `CHK("activeId1", aid[1], activeId[1])
  endtask : wr
  task automatic rd(input logic [1:0] sel, input int lp, input logic [63:0] e);
    rdSel = sel; rdLp = lp[0:0]; rdValid = 1'b1;
    rdQ.push_back(e);
    @(posedge clk_sys); #1 rdValid = 1'b0;
    @(posedge clk_sys); #1;
  endtask : rd
  task automatic query(input logic [31:0] lf, input logic [31:0] sb, input logic [31:0] eb, input logic [31:0] ed);
    queryLeaf = lf; querySub = sb; queryValid = 1'b1;
    qQ.push_back({eb, ed});
    @(posedge clk_sys); #1 queryValid = 1'b0;
    @(posedge clk_sys); #1;
  endtask : query
  // select an event and ID, then read the counter back
  task automatic ctr(input int lp, input logic [9:0] id, input logic [7:0] code, input logic [63:0] e);
    wr(2'h1, lp, {22'h0, id, 24'h0, code}, 1'b0);
    rd(2'h2, lp, e);
  endtask : ctr
  function automatic logic [63:0] expv(input int code, input int id);
    if (code == 1) return {32'h0, occ[id]};
    if (code == 2) return {32'h0, tot[id]};
    return {32'h0, loc[id]};
  endfunction : expv
  // random traffic tagged with the current IDs; counters wrap at 32 bits
  task automatic traffic(input int n);
    for (int i = 0; i < n; i++) begin
      fillPulse = 2'($urandom_range(3)); missPulse = 2'($urandom_range(3)); missLocal = 2'($urandom_range(3));
      for (int p = 0; p < 2; p++) begin
        if (fillPulse[p]) occ[aid[p]]++;
        if (missPulse[p]) tot[aid[p]]++;
        if (missPulse[p] && missLocal[p]) loc[aid[p]]++;
      end
      @(posedge clk_sys); #1;
    end
    fillPulse = '0; missPulse = '0; missLocal = '0;
  endtask : traffic
  // evictions run alone, so a fill never meets a removal in one cycle
  task automatic evict(input int id, input int n);
    evictId = id[9:0]; evictPulse = 1'b1;
    for (int i = 0; i < n; i++) begin
      if (occ[id] > 0) occ[id]--;
      @(posedge clk_sys); #1;
    end
    evictPulse = 1'b0;
    @(posedge clk_sys); #1;
  endtask : evict
  // ============================================================
  // watcher: answers are taken at the falling edge, where they are settled
  always @(negedge clk_sys) begin
    if (resetn === 1'b1) begin
      if (wrDone === 1'b1 || gpFault === 1'b1)
        `CHK("write answer", (wrQ.size() ? wrQ.pop_front() : 2'bxx), {wrDone, gpFault})
      if (rdDone === 1'b1)
        `CHK("rdData", (rdQ.size() ? rdQ.pop_front() : 64'hx), rdData)
      if (queryDone === 1'b1)
        `CHK("query", (qQ.size() ? qQ.pop_front() : 64'hx), {queryEbx, queryEdx})
    end
  end
  task automatic summarize();
    if (fail_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize
  initial begin
    #200000;
    fail_count++;
    summarize();
  end
  // ============================================================
  // main sequence
  initial begin
    int a0;
    int a1;
    resetn = 1'b0; wrValid = 1'b0; rdValid = 1'b0; queryValid = 1'b0; evictPulse = 1'b0;
    wrSel = '0; wrLp = '0; wrData = '0; rdSel = '0; rdLp = '0; queryLeaf = '0; querySub = '0;
    fillPulse = '0; missPulse = '0; missLocal = '0; evictId = '0;
    aid[0] = '0; aid[1] = '0;
    void'($urandom(47));
    repeat (4) @(posedge clk_sys);
    #1 `CHK("reset activeId", 20'h0, activeId)
    resetn = 1'b1;
    @(posedge clk_sys); #1;
    query(32'h7, 32'h0, 32'h0000_1000, 32'h0);
    query(32'hF, 32'h0, {22'h0, monitor_pkg::MAX_ID}, 32'h2);
    query(32'h5, 32'h0, 32'h0, 32'h0);
    wr(2'h0, 0, 64'h5, 1'b0);
    wr(2'h0, 1, 64'h5, 1'b0);
    wr(2'h0, 0, 64'h10, 1'b1);
    wr(2'h0, 1, 64'hF, 1'b0);
    wr(2'h2, 0, 64'h1, 1'b1);
    wr(2'h3, 1, 64'h1, 1'b1);
    rd(2'h3, 0, 64'h0);
    for (int r = 0; r < 4; r++) begin
      a0 = $urandom_range(15);
      a1 = (r == 0) ? a0 : $urandom_range(15);
      wr(2'h0, 0, 64'(a0), 1'b0);
      wr(2'h0, 1, 64'(a1), 1'b0);
      traffic(20);
      evict(a0, 3);
      evict($urandom_range(15), 2);
      for (int c = 1; c <= 3; c++) begin
        ctr(r % 2, a0[9:0], c[7:0], expv(c, a0));
        ctr(1 - r % 2, a1[9:0], c[7:0], expv(c, a1));
      end
    end
    // a read repeated with no traffic between must give the same figure
    for (int id = 0; id < 16; id++) begin
      ctr(0, id[9:0], 8'h1, expv(1, id));
      rd(2'h2, 0, expv(1, id));
    end
    ctr(0, 10'h3, 8'h0, ERRV);
    ctr(1, 10'h3, 8'h4, ERRV);
    ctr(0, 10'h3, 8'hFF, ERRV);
    ctr(1, 10'h10, 8'h1, ERRV);
    ctr(0, 10'h3FF, 8'h2, ERRV);
    repeat (3) @(posedge clk_sys);
    `CHK("pending answers", 0, wrQ.size() + rdQ.size() + qQ.size())
    summarize();
  end
endmodule : test_shared_resource_monitor_ids
